/* File: ccu_capcmp.sv */
// capture/compare unit with 16-bit timebase and apb register access
`timescale 1ns/1ps
`include "ccu_cfg.svh"
module ccu_capcmp
    import ccu_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe,
    input  wire logic        ext_clk_in,
    input  wire logic        sleep_mode,
    output logic             event_flag,
    output logic             special_trigger
);

    ccu_ctrl_t   ctrl_ff;
    ccu_tbcfg_t  tbcfg_ff;
    logic [15:0] hold_ff;
    logic [15:0] tb_cnt_ff;
    logic [1:0]  div_cnt_ff;
    logic        pin_prev_ff;
    logic        ext_prev_ff;
    logic        match_q_ff;
    logic        tb_rst_pend_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        flag_ff;
    logic        pin_lat_ff;
    logic        pin_oe_ff;
    logic        special_ff;

    logic        pin_s;
    logic        ext_s;
    ccu_mode_t   mode;
    logic        is_capture;
    logic        is_compare;
    logic        pin_rise;
    logic        pin_fall;
    logic        ext_rise;
    logic        instr_tick;
    logic        tb_tick;
    logic        presc_fire;
    logic        presc_clear;
    logic        cap_evt;
    logic        match_now;
    logic        cmp_evt;
    logic        setup;
    logic        wr_en;
    logic        addr_ok;
    logic        wr_ctrl;
    logic        wr_hold_lo;
    logic        wr_hold_hi;
    logic        wr_status;
    logic        wr_tbcfg;
    logic        wr_tb_lo;
    logic        wr_tb_hi;
    logic [31:0] rd_mux;
    ccu_mode_t   wr_mode;

    assign mode    = ccu_mode_t'(ctrl_ff.mode);
    assign wr_mode = ccu_mode_t'(pwdata[3:0]);

    // pin and external clock come from outside pclk
    ccu_sync2 u_pin_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pin_in),
        .q       (pin_s)
    );

    ccu_sync2 u_ext_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (ext_clk_in),
        .q       (ext_s)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_prev_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end
        else
        begin
            pin_prev_ff <= pin_s;
            ext_prev_ff <= ext_s;
        end
    end

    assign pin_rise = pin_s && !pin_prev_ff;
    assign pin_fall = !pin_s && pin_prev_ff;
    assign ext_rise = ext_s && !ext_prev_ff;

    // mode decode, off and unused codes idle
    always_comb
    begin
        is_capture = 1'b0;
        is_compare = 1'b0;
        case (mode)
            CCU_CAP_FALL, CCU_CAP_RISE, CCU_CAP_RISE4, CCU_CAP_RISE16:
                is_capture = 1'b1;
            CCU_CMP_TOGGLE, CCU_CMP_SET, CCU_CMP_CLR, CCU_CMP_SWEV, CCU_CMP_TRIG:
                is_compare = 1'b1;
            default:
            begin
                is_capture = 1'b0;
                is_compare = 1'b0;
            end
        endcase
    end

    // apb slave, no wait states, answer registered
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign addr_ok = (paddr == `CCU_ADDR_CTRL)    || (paddr == `CCU_ADDR_HOLD_LO) ||
                     (paddr == `CCU_ADDR_HOLD_HI) || (paddr == `CCU_ADDR_STATUS)  ||
                     (paddr == `CCU_ADDR_TBCFG)   || (paddr == `CCU_ADDR_TB_LO)   ||
                     (paddr == `CCU_ADDR_TB_HI);

    assign wr_ctrl    = wr_en && (paddr == `CCU_ADDR_CTRL);
    assign wr_hold_lo = wr_en && (paddr == `CCU_ADDR_HOLD_LO);
    assign wr_hold_hi = wr_en && (paddr == `CCU_ADDR_HOLD_HI);
    assign wr_status  = wr_en && (paddr == `CCU_ADDR_STATUS);
    assign wr_tbcfg   = wr_en && (paddr == `CCU_ADDR_TBCFG);
    assign wr_tb_lo   = wr_en && (paddr == `CCU_ADDR_TB_LO);
    assign wr_tb_hi   = wr_en && (paddr == `CCU_ADDR_TB_HI);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `CCU_ADDR_CTRL:    rd_mux[7:0]  = ctrl_ff;
            `CCU_ADDR_HOLD_LO: rd_mux[7:0]  = hold_ff[7:0];
            `CCU_ADDR_HOLD_HI: rd_mux[7:0]  = hold_ff[15:8];
            `CCU_ADDR_STATUS:
            begin
                rd_mux[`CCU_STAT_FLAG_BIT] = flag_ff;
                rd_mux[`CCU_STAT_PIN_BIT]  = pin_lat_ff;
            end
            `CCU_ADDR_TBCFG:   rd_mux[1:0]  = tbcfg_ff;
            `CCU_ADDR_TB_LO:   rd_mux[7:0]  = tb_cnt_ff[7:0];
            `CCU_ADDR_TB_HI:   rd_mux[7:0]  = tb_cnt_ff[15:8];
            default:           rd_mux       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !addr_ok;
            prdata_ff  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // control register; a direct mode write keeps the prescaler count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_ff <= `CCU_CTRL_RST;
        else if (wr_ctrl)
            ctrl_ff <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tbcfg_ff <= `CCU_TBCFG_RST;
        else if (wr_tbcfg)
        begin
            tbcfg_ff.run     <= pwdata[`CCU_TBCFG_RUN_BIT];
            tbcfg_ff.src_ext <= pwdata[`CCU_TBCFG_EXT_BIT];
        end
    end

    // instruction clock enable, one pulse every four pclk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt_ff <= 2'h0;
        else
            div_cnt_ff <= div_cnt_ff + 2'h1;
    end

    assign instr_tick = (div_cnt_ff == 2'(`CCU_INSTR_DIV - 1));

    // timebase ticks from instruction clock or external clock
    assign tb_tick = tbcfg_ff.run &&
                     (tbcfg_ff.src_ext ? ext_rise : (instr_tick && !sleep_mode));

    // pending trigger resets count at next tick unless match removed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tb_cnt_ff <= `CCU_TB_RST;
        else if (wr_tb_lo)
            tb_cnt_ff[7:0] <= pwdata[7:0];
        else if (wr_tb_hi)
            tb_cnt_ff[15:8] <= pwdata[7:0];
        else if (tb_tick && tb_rst_pend_ff && (hold_ff == tb_cnt_ff))
            tb_cnt_ff <= 16'h0000;
        else if (tb_tick)
            tb_cnt_ff <= tb_cnt_ff + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tb_rst_pend_ff <= 1'b0;
        else if (cmp_evt && (mode == CCU_CMP_TRIG))
            tb_rst_pend_ff <= 1'b1;
        else if (tb_tick || (hold_ff != tb_cnt_ff) || (mode != CCU_CMP_TRIG))
            tb_rst_pend_ff <= 1'b0;
    end

    // prescaler held clear unless in a capture mode
    assign presc_clear = !is_capture;

    // count qualified rising edges, fire on 4th or 16th
    ccu_presc
    #(
        .DIV_A (`CCU_PS_A),
        .DIV_B (`CCU_PS_B)
    )
    u_presc
    (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (presc_clear),
        .edge_in (pin_rise),
        .sel_b   (mode == CCU_CAP_RISE16),
        .fire    (presc_fire)
    );

    // runs in sleep too, count moves in sleep only on the external clock
    always_comb
    begin
        cap_evt = 1'b0;
        case (mode)
            CCU_CAP_FALL:   cap_evt = pin_fall;
            CCU_CAP_RISE:   cap_evt = pin_rise;
            CCU_CAP_RISE4:  cap_evt = presc_fire;
            CCU_CAP_RISE16: cap_evt = presc_fire;
            default:        cap_evt = 1'b0;
        endcase
    end

    // equality check, compare halted in sleep
    assign match_now = is_compare && !sleep_mode && (hold_ff == tb_cnt_ff);
    assign cmp_evt   = match_now && !match_q_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match_q_ff <= 1'b0;
        else
            match_q_ff <= match_now;
    end

    // capture wins over a software write, newest value kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_ff <= `CCU_HOLD_RST;
        else if (cap_evt)
            hold_ff <= tb_cnt_ff;
        else if (wr_hold_lo)
            hold_ff[7:0] <= pwdata[7:0];
        else if (wr_hold_hi)
            hold_ff[15:8] <= pwdata[7:0];
    end

    // hardware only sets; write one clears, set wins
    // mode switch edges may set the flag spuriously
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_ff <= 1'b0;
        else if (cap_evt || cmp_evt)
            flag_ff <= 1'b1;
        else if (wr_status && pwdata[`CCU_STAT_FLAG_BIT])
            flag_ff <= 1'b0;
    end

    // zero control write forces latch low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_lat_ff <= 1'b0;
        else if (wr_ctrl)
        begin
            case (wr_mode)
                CCU_OFF:     pin_lat_ff <= 1'b0;
                CCU_CMP_SET: pin_lat_ff <= 1'b0;
                CCU_CMP_CLR: pin_lat_ff <= 1'b1;
                default:     pin_lat_ff <= pin_lat_ff;
            endcase
        end
        else if (cmp_evt)
        begin
            case (mode)
                CCU_CMP_TOGGLE: pin_lat_ff <= !pin_lat_ff;
                CCU_CMP_SET:    pin_lat_ff <= 1'b1;
                CCU_CMP_CLR:    pin_lat_ff <= 1'b0;
                default:        pin_lat_ff <= pin_lat_ff;
            endcase
        end
    end

    // drive only in pin modes; port direction set by software
    // software event mode leaves the pin alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_oe_ff <= 1'b0;
        else
            pin_oe_ff <= (mode == CCU_CMP_TOGGLE) || (mode == CCU_CMP_SET) ||
                         (mode == CCU_CMP_CLR);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            special_ff <= 1'b0;
        else
            special_ff <= cmp_evt && (mode == CCU_CMP_TRIG);
    end

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign pin_out         = pin_lat_ff;
    assign pin_oe          = pin_oe_ff;
    assign event_flag      = flag_ff;
    assign special_trigger = special_ff;

endmodule

/* File: ccu_capcmp_asserts.sv */
// concurrent checks on the capture/compare unit ports
`timescale 1ns/1ps
`include "ccu_cfg.svh"
module ccu_capcmp_asserts
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pin_in,
    input wire logic        pin_out,
    input wire logic        pin_oe,
    input wire logic        ext_clk_in,
    input wire logic        sleep_mode,
    input wire logic        event_flag,
    input wire logic        special_trigger
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic wr_acc = psel && penable && pwrite;
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence mode_wr(logic [3:0] m);
        wr_acc && paddr == `CCU_ADDR_CTRL && pwdata[3:0] == m;
    endsequence
    sequence flag_keep;
        event_flag && !(wr_acc && paddr == `CCU_ADDR_STATUS && pwdata[0]);
    endsequence
    ready_after_setup_a: assert property (apb_setup |=> pready)
        else $error("no ready after setup");
    ready_one_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    flag_sticky_a: assert property (flag_keep |=> event_flag)
        else $error("flag dropped without clear");
    trig_pulse_a: assert property (special_trigger |=> !special_trigger)
        else $error("trigger not a pulse");
    trig_flag_a: assert property (special_trigger |-> event_flag)
        else $error("trigger without flag");
    off_quiet_a: assert property (mode_wr(4'h0) |=> ##1 !pin_oe && !pin_out)
        else $error("pin active after off");
    swev_no_pin_a: assert property (mode_wr(4'ha) |=> ##1 !pin_oe [*2])
        else $error("pin driven in flag-only mode");
endmodule

bind ccu_capcmp ccu_capcmp_asserts chk_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .ext_clk_in, .sleep_mode, .event_flag, .special_trigger);

/* File: ccu_capcmp_test.sv */
// self-checking bench for the capture/compare unit
`timescale 1ns/1ps
`include "ccu_cfg.svh"
module ccu_capcmp_test
    import ccu_pkg::*;
;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} ccu_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
    logic        pin_in, pin_out, pin_oe, ext_clk_in, sleep_mode, event_flag, special_trigger;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv, tbv;
    int          n_errors = 0;
    int          n_trig = 0;
    int          checked = 0;
    ccu_mode_t   cm [5] = '{CCU_CMP_TOGGLE, CCU_CMP_SET, CCU_CMP_CLR, CCU_CMP_SWEV, CCU_CMP_TRIG};
    logic [1:0]  co [5] = '{2'b11, 2'b11, 2'b10, 2'b00, 2'b00};
    ccu_row_t    rows [9] = '{
        '{8'h04, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h18, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h04, 1'b1, 32'h1a5, 32'h0, 1'b0}, '{8'h04, 1'b0, 32'h0, 32'ha5, 1'b0},
        '{8'h08, 1'b1, 32'h3c, 32'h0, 1'b0}, '{8'h08, 1'b0, 32'h0, 32'h3c, 1'b0},
        '{8'h00, 1'b1, 32'hf0, 32'h0, 1'b0}, '{8'h00, 1'b0, 32'h0, 32'hf0, 1'b0},
        '{8'h1c, 1'b1, 32'h5, 32'h0, 1'b1}};

    ccu_capcmp dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .pin_in, .pin_out, .pin_oe, .ext_clk_in, .sleep_mode, .event_flag, .special_trigger);
    ccu_pin_src src (.pclk, .pin_in, .ext_clk_in);

    // counts special trigger pulses seen at the clock edge
    always @(posedge pclk)
        if (special_trigger === 1'b1)
            n_trig++;

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task wait_flag;
        int n;
        n = 0;
        while (event_flag !== 1'b1 && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
    endtask

    task cap_edges(input logic [3:0] m, input int n, input int pre);
        wr(`CCU_ADDR_CTRL, 32'h0);
        wr(`CCU_ADDR_CTRL, {28'h0, m});
        repeat (pre) src.pulse;
        wr(`CCU_ADDR_CTRL, 32'h0);
        wr(`CCU_ADDR_CTRL, {28'h0, m});
        wr(`CCU_ADDR_STATUS, 32'h1);
        @(posedge pclk);
        repeat (n - 1) src.pulse;
        chk("early", 32'(event_flag), 32'h0);
        src.pulse;
        chk("fire", 32'(event_flag), 32'h1);
    endtask

    task wrap_up;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        wrap_up;
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, sleep_mode} = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("rst", 32'({event_flag, pin_oe, pin_out, special_trigger}), 32'h0);
        foreach (rows[i])
        begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            chk("rdata", rdv, rows[i].x);
            chk("err", 32'(erv), 32'(rows[i].e));
        end
        $display("regs done");
        cap_edges(4'h4, 1, 0);
        cap_edges(4'h5, 1, 0);
        cap_edges(4'h6, 4, 0);
        cap_edges(4'h7, 16, 0);
        cap_edges(4'h6, 4, 2);
        wr(`CCU_ADDR_CTRL, 32'h0);
        wr(`CCU_ADDR_TB_LO, 32'h34);
        wr(`CCU_ADDR_TB_HI, 32'h12);
        wr(`CCU_ADDR_TBCFG, 32'h3);
        wr(`CCU_ADDR_CTRL, 32'h5);
        wr(`CCU_ADDR_STATUS, 32'h1);
        @(posedge pclk) sleep_mode <= 1'b1;
        repeat (3) src.tick;
        src.pulse;
        apb(`CCU_ADDR_HOLD_LO, 1'b0, 32'h0);
        chk("cap lo", rdv, 32'h37);
        apb(`CCU_ADDR_HOLD_HI, 1'b0, 32'h0);
        chk("cap hi", rdv, 32'h12);
        src.tick;
        src.pulse;
        apb(`CCU_ADDR_HOLD_LO, 1'b0, 32'h0);
        chk("recap", rdv, 32'h38);
        chk("sticky", 32'(event_flag), 32'h1);
        wr(`CCU_ADDR_STATUS, 32'h1);
        @(posedge pclk);
        chk("clear", 32'(event_flag), 32'h0);
        @(posedge pclk) sleep_mode <= 1'b0;
        $display("capture done");
        foreach (cm[i])
        begin
            wr(`CCU_ADDR_CTRL, 32'h0);
            wr(`CCU_ADDR_TBCFG, 32'h0);
            wr(`CCU_ADDR_TB_LO, 32'h0);
            wr(`CCU_ADDR_TB_HI, 32'h0);
            wr(`CCU_ADDR_HOLD_LO, 32'h10);
            wr(`CCU_ADDR_HOLD_HI, 32'h0);
            wr(`CCU_ADDR_CTRL, {28'h0, cm[i]});
            wr(`CCU_ADDR_STATUS, 32'h1);
            wr(`CCU_ADDR_TBCFG, 32'h1);
            wait_flag;
            chk("match flag", 32'(event_flag), 32'h1);
            repeat (2) @(posedge pclk);
            chk("pin", 32'({pin_oe, pin_out}), 32'(co[i]));
            apb(`CCU_ADDR_TB_LO, 1'b0, 32'h0);
            chk("tb", 32'(rdv[7:0] < 8'h10), 32'(cm[i] == CCU_CMP_TRIG));
        end
        wr(`CCU_ADDR_CTRL, 32'h0);
        chk("trig count", n_trig, 32'h1);
        $display("compare done");
        @(posedge pclk) sleep_mode <= 1'b1;
        apb(`CCU_ADDR_TB_LO, 1'b0, 32'h0);
        tbv = rdv;
        repeat (20) @(posedge pclk);
        apb(`CCU_ADDR_TB_LO, 1'b0, 32'h0);
        chk("frozen", rdv, tbv);
        @(posedge pclk) sleep_mode <= 1'b0;
        repeat (20) @(posedge pclk);
        apb(`CCU_ADDR_TB_LO, 1'b0, 32'h0);
        chk("resumed", 32'(rdv > tbv), 32'h1);
        $display("sleep done");
        wrap_up;
    end
endmodule

/* File: ccu_cfg.svh */
// register offsets, field positions, reset values and counts for the capture/compare unit
`ifndef CCU_CFG_SVH
`define CCU_CFG_SVH

`define CCU_ADDR_CTRL     8'h00
`define CCU_ADDR_HOLD_LO  8'h04
`define CCU_ADDR_HOLD_HI  8'h08
`define CCU_ADDR_STATUS   8'h0c
`define CCU_ADDR_TBCFG    8'h10
`define CCU_ADDR_TB_LO    8'h14
`define CCU_ADDR_TB_HI    8'h18

`define CCU_CTRL_RST      8'h00
`define CCU_HOLD_RST      16'h0000
`define CCU_TB_RST        16'h0000
`define CCU_TBCFG_RST     2'h0

`define CCU_STAT_FLAG_BIT 0
`define CCU_STAT_PIN_BIT  1
`define CCU_TBCFG_RUN_BIT 0
`define CCU_TBCFG_EXT_BIT 1

`define CCU_INSTR_DIV     4
`define CCU_PS_A          4
`define CCU_PS_B          16

`endif

/* File: ccu_pin_src.sv */
// far-side model: capture pin source and external timebase clock
`timescale 1ns/1ps
module ccu_pin_src
(
    input  wire logic pclk,
    output logic      pin_in,
    output logic      ext_clk_in
);
    initial
    begin
        pin_in = 1'b0;
        ext_clk_in = 1'b0;
    end
    task pulse;
        @(posedge pclk) pin_in <= 1'b1;
        repeat (6) @(posedge pclk);
        pin_in <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
    task tick;
        @(posedge pclk) ext_clk_in <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_clk_in <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
endmodule

/* File: ccu_pkg.sv */
// types shared by the capture/compare unit files
package ccu_pkg;

    typedef enum logic [3:0] {
        CCU_OFF        = 4'h0,
        CCU_CMP_TOGGLE = 4'h2,
        CCU_CAP_FALL   = 4'h4,
        CCU_CAP_RISE   = 4'h5,
        CCU_CAP_RISE4  = 4'h6,
        CCU_CAP_RISE16 = 4'h7,
        CCU_CMP_SET    = 4'h8,
        CCU_CMP_CLR    = 4'h9,
        CCU_CMP_SWEV   = 4'ha,
        CCU_CMP_TRIG   = 4'hb
    } ccu_mode_t;

    typedef struct packed {
        logic [3:0] upper_bits;
        logic [3:0] mode;
    } ccu_ctrl_t;

    typedef struct packed {
        logic src_ext;
        logic run;
    } ccu_tbcfg_t;

endpackage

/* File: ccu_presc.sv */
// capture edge prescaler: one fire per DIV_A or DIV_B qualified rising edges
`timescale 1ns/1ps
module ccu_presc
#(
    parameter int DIV_A = 4,
    parameter int DIV_B = 16,
    parameter int CW    = $clog2(DIV_B)
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clear,
    input  wire logic edge_in,
    input  wire logic sel_b,
    output logic      fire
);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] limit;

    assign limit = sel_b ? CW'(DIV_B - 1) : CW'(DIV_A - 1);
    assign fire  = edge_in && !clear && (cnt_ff == limit);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= '0;
        else if (clear)
            cnt_ff <= '0;
        else if (fire)
            cnt_ff <= '0;
        else if (edge_in)
            cnt_ff <= cnt_ff + CW'(1);
    end

endmodule

/* File: ccu_sync2.sv */
// two-flop synchroniser for a level from outside the pclk domain
`timescale 1ns/1ps
module ccu_sync2
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic d,
    output logic      q
);

    logic meta_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= 1'b0;
            q       <= 1'b0;
        end
        else
        begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule
